// ===== src/pamx_cfg.svh
// Constants for the port A and reset pin multiplexer.
// Assumes inclusion by the package, the design files and the bench.
`ifndef PAMX_CFG_SVH
`define PAMX_CFG_SVH
`define PAMX_RST_SYNC_CYC 16
`define PAMX_CNT_W 5
`define PAMX_SEL_GPIO 2'h0
`define PAMX_SEL_PWM 2'h1
`define PAMX_SEL_TMR 2'h2
`define PAMX_SEL_FLT 2'h3
`define PAMX_PINS 7
`define PAMX_PWM_CH 6
`endif

// ===== src/pamx_pkg.sv
// Types for the port A and reset pin multiplexer.
// Assumes pamx_cfg.svh is on the include path.
`include "pamx_cfg.svh"
package pamx_pkg;
   typedef logic [1:0] pamx_sel_t;
   typedef enum logic [1:0] {PAMX_RS_HOLD, PAMX_RS_COUNT, PAMX_RS_RUN} pamx_rst_st_t;
endpackage : pamx_pkg

// ===== src/pamx_sync3.sv
// Three-stage synchroniser with agreement filter for a pin input.
// Assumes a single clock domain; output changes when stages two and three agree.
`timescale 1ns/100ps
`include "pamx_cfg.svh"
module pamx_sync3
   import pamx_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic init_val,
   input wire logic pin_in,
   output logic pin_out
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   // First stage feeds only the second
   always_ff @(posedge core_clk)
   begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
   end
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         pin_out <= init_val;
      end
      else if (s2_r == s3_r)
      begin
         pin_out <= s3_r;
      end
   end
endmodule : pamx_sync3

// ===== src/pamx_rst_ctl.sv
// Internal reset sequencer: holds while a source is active, releases after a count.
// Assumes all reset requests are already synchronised to core_clk.
`timescale 1ns/100ps
`include "pamx_cfg.svh"
module pamx_rst_ctl
   import pamx_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic rst_req,
   output logic chip_rst_n
);
   pamx_rst_st_t st_r;
   logic [`PAMX_CNT_W-1:0] cnt_r;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n || rst_req)
      begin
         st_r <= PAMX_RS_HOLD;
         cnt_r <= '0;
      end
      else
      begin
         case (st_r)
            PAMX_RS_HOLD:
            begin
               st_r <= PAMX_RS_COUNT;
               cnt_r <= '0;
            end
            PAMX_RS_COUNT:
            begin
               cnt_r <= cnt_r + `PAMX_CNT_W'(1);
               if (cnt_r == `PAMX_CNT_W'(`PAMX_RST_SYNC_CYC - 1))
               begin
                  st_r <= PAMX_RS_RUN;
               end
            end
            default:
            begin
               st_r <= PAMX_RS_RUN;
            end
         endcase
      end
   end

   // Release happens on a clock edge, never asynchronously
   always_ff @(posedge core_clk)
   begin
      if (!rst_n || rst_req)
      begin
         chip_rst_n <= 1'b0;
      end
      else
      begin
         chip_rst_n <= (st_r == PAMX_RS_COUNT) &&
            (cnt_r == `PAMX_CNT_W'(`PAMX_RST_SYNC_CYC - 1)) ? 1'b1 :
            (st_r == PAMX_RS_RUN);
      end
   end
endmodule : pamx_rst_ctl

// ===== src/pamx_top.sv
// Port A and reset pin multiplexer with internal reset sequencing.
// Assumes selections come from the system integration unit, held by core_clk logic.
`timescale 1ns/100ps
`include "pamx_cfg.svh"
module pamx_top
   import pamx_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic por_rst,
   input wire logic watchdog_reset,
   input wire logic sw_rst,
   input wire logic reset_pin_n_in,
   output logic port_a_bit7_io_out,
   output logic port_a_bit7_io_oe,
   input wire logic rst_pin_gpio_sel,
   input wire logic port_a_bit7_dout,
   input wire logic port_a_bit7_dir,
   output logic port_a_bit7_din,
   input wire logic [6:0] port_a_pin_in,
   output logic [6:0] port_a_pin_out,
   output logic [6:0] port_a_pin_oe,
   input wire logic [6:0] gpio_dout,
   input wire logic [6:0] gpio_dir,
   output logic [6:0] gpio_din,
   input wire logic [5:0] pwm_alt_sel,
   input wire logic [5:0] pwm_out_ch,
   input wire logic [1:0] tmr_alt_sel,
   input wire logic [1:0] flt_alt_sel,
   input wire logic flt0_alt_sel,
   input wire logic timer_a_ch2_out,
   input wire logic timer_a_ch2_oe,
   input wire logic timer_a_ch3_out,
   input wire logic timer_a_ch3_oe,
   output logic timer_a_ch2_in,
   output logic timer_a_ch3_in,
   input wire logic port_b_bit4_in,
   input wire logic flt1_from_b4_sel,
   input wire logic [5:0] pwm_fault_mask,
   output logic pwm_fault_in_0,
   output logic pwm_fault_in_1,
   output logic pwm_fault_in_2,
   output logic chip_rst_n
);
   // -------------------------------------------------------------------
   // Selection decode
   // -------------------------------------------------------------------
   pamx_sel_t sel [`PAMX_PINS];
   logic [6:0] pin_sync;
   logic rst_pin_sync;
   logic pin_rst_req;
   logic rst_req;
   logic fault_any;
   logic f0_nxt;
   logic f1_nxt;
   logic f2_nxt;
   logic [6:0] out_nxt;
   logic [6:0] oe_nxt;
   logic b4_sync;

   // Priority per pin: PWM, then timer, then fault, else GPIO
   function automatic pamx_sel_t pick_sel(input logic p, input logic t, input logic f);
      pamx_sel_t s;
      s = `PAMX_SEL_GPIO;
      if (p)
      begin
         s = `PAMX_SEL_PWM;
      end
      else if (t)
      begin
         s = `PAMX_SEL_TMR;
      end
      else if (f)
      begin
         s = `PAMX_SEL_FLT;
      end
      return s;
   endfunction : pick_sel

   always_comb
   begin
      sel[0] = pick_sel(pwm_alt_sel[0], 1'b0, 1'b0);
      sel[1] = pick_sel(pwm_alt_sel[1], 1'b0, 1'b0);
      sel[2] = pick_sel(pwm_alt_sel[2], 1'b0, 1'b0);
      sel[3] = pick_sel(pwm_alt_sel[3], 1'b0, 1'b0);
      sel[4] = pick_sel(pwm_alt_sel[4], tmr_alt_sel[0], flt_alt_sel[0]);
      sel[5] = pick_sel(pwm_alt_sel[5], tmr_alt_sel[1], flt_alt_sel[1]);
      sel[6] = pick_sel(1'b0, 1'b0, flt0_alt_sel);
   end

   // -------------------------------------------------------------------
   // Pin input synchronisers
   // -------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `PAMX_PINS; gi++)
      begin : g_sync
         pamx_sync3 u_sync (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .init_val(1'b1),
            .pin_in(port_a_pin_in[gi]),
            .pin_out(pin_sync[gi])
         );
      end
   endgenerate

   pamx_sync3 u_sync_rst (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .init_val(1'b1),
      .pin_in(reset_pin_n_in),
      .pin_out(rst_pin_sync)
   );

   pamx_sync3 u_sync_b4 (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .init_val(1'b1),
      .pin_in(port_b_bit4_in),
      .pin_out(b4_sync)
   );

   // -------------------------------------------------------------------
   // Reset sequencing
   // -------------------------------------------------------------------
   // Pin reset only counts while the pin is in its reset role
   assign pin_rst_req = !rst_pin_gpio_sel && !rst_pin_sync;
   assign rst_req = pin_rst_req || por_rst || watchdog_reset || sw_rst;

   pamx_rst_ctl u_rst (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .rst_req(rst_req),
      .chip_rst_n(chip_rst_n)
   );

   // -------------------------------------------------------------------
   // Output muxing
   // -------------------------------------------------------------------
   // Faults are active low at the pin; fault gates masked PWM channels
   always_comb
   begin
      f0_nxt = (sel[6] == `PAMX_SEL_FLT) && !pin_sync[6];
      f1_nxt = ((sel[4] == `PAMX_SEL_FLT) && !pin_sync[4]) ||
         (flt1_from_b4_sel && !b4_sync);
      f2_nxt = (sel[5] == `PAMX_SEL_FLT) && !pin_sync[5];
      fault_any = f0_nxt || f1_nxt || f2_nxt;
   end

   always_comb
   begin
      out_nxt = '0;
      oe_nxt = '0;
      for (int i = 0; i < `PAMX_PINS; i++)
      begin
         case (sel[i])
            `PAMX_SEL_PWM:
            begin
               out_nxt[i] = pwm_out_ch[i] && !(fault_any && pwm_fault_mask[i]);
               oe_nxt[i] = 1'b1;
            end
            `PAMX_SEL_TMR:
            begin
               out_nxt[i] = (i == 4) ? timer_a_ch2_out : timer_a_ch3_out;
               oe_nxt[i] = (i == 4) ? timer_a_ch2_oe : timer_a_ch3_oe;
            end
            `PAMX_SEL_FLT:
            begin
               out_nxt[i] = 1'b0;
               oe_nxt[i] = 1'b0;
            end
            default:
            begin
               out_nxt[i] = gpio_dout[i];
               oe_nxt[i] = gpio_dir[i] && chip_rst_n;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         port_a_pin_out <= '0;
         port_a_pin_oe <= '0;
      end
      else
      begin
         port_a_pin_out <= out_nxt;
         port_a_pin_oe <= oe_nxt;
      end
   end

   // Open drain only: the pin is never driven high
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         port_a_bit7_io_out <= 1'b0;
         port_a_bit7_io_oe <= 1'b0;
      end
      else
      begin
         port_a_bit7_io_out <= 1'b0;
         port_a_bit7_io_oe <= rst_pin_gpio_sel && port_a_bit7_dir && !port_a_bit7_dout;
      end
   end

   // Inputs fan out to GPIO, bit 7 and timer users regardless of selection; fault inputs follow the fault selections
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         gpio_din <= '1;
         port_a_bit7_din <= 1'b1;
         timer_a_ch2_in <= 1'b1;
         timer_a_ch3_in <= 1'b1;
         pwm_fault_in_0 <= 1'b0;
         pwm_fault_in_1 <= 1'b0;
         pwm_fault_in_2 <= 1'b0;
      end
      else
      begin
         gpio_din <= pin_sync;
         port_a_bit7_din <= rst_pin_sync;
         timer_a_ch2_in <= pin_sync[4];
         timer_a_ch3_in <= pin_sync[5];
         pwm_fault_in_0 <= f0_nxt;
         pwm_fault_in_1 <= f1_nxt;
         pwm_fault_in_2 <= f2_nxt;
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   a_bit7_no_high: assert property (@(posedge core_clk) disable iff (!rst_n)
      port_a_bit7_io_oe |-> !port_a_bit7_io_out) else $error("bit7 drove high");
   a_bit7_oe_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
      port_a_bit7_io_oe |-> $past(rst_pin_gpio_sel && port_a_bit7_dir && !port_a_bit7_dout))
      else $error("bit7 pulled low without request");
   a_bit7_reset_role: assert property (@(posedge core_clk) disable iff (!rst_n)
      !rst_pin_gpio_sel |=> !port_a_bit7_io_oe) else $error("bit7 driven in reset role");
   a_pin_rst_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      pin_rst_req |=> !chip_rst_n) else $error("pin reset not held");
   a_any_rst_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_req |=> !chip_rst_n) else $error("reset request not held");
   a_gpio_mode_ignore: assert property (@(posedge core_clk) disable iff (!rst_n)
      (rst_pin_gpio_sel && !por_rst && !watchdog_reset && !sw_rst && chip_rst_n)
      |=> chip_rst_n) else $error("reset taken from pin in gpio mode");
   a_rst_release_cnt: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(chip_rst_n) |-> !$past(rst_req, `PAMX_RST_SYNC_CYC))
      else $error("release too early");
   a_after_reset_off: assert property (@(posedge core_clk)
      !rst_n |=> port_a_pin_oe == 7'h00) else $error("pin driven after reset");
   a_gpio_held_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!chip_rst_n && !pwm_alt_sel[0]) |=> !port_a_pin_oe[0])
      else $error("gpio pin driven during internal reset");
   a_gpio_dir_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      (chip_rst_n && !pwm_alt_sel[0]) |=> port_a_pin_oe[0] == $past(gpio_dir[0]))
      else $error("gpio direction not applied");
   a_pwm_out_only: assert property (@(posedge core_clk) disable iff (!rst_n)
      pwm_alt_sel[0] |=> port_a_pin_oe[0]) else $error("pwm pin not output");
   a_pwm_value: assert property (@(posedge core_clk) disable iff (!rst_n)
      (pwm_alt_sel[2] && !fault_any) |=> port_a_pin_out[2] == $past(pwm_out_ch[2]))
      else $error("pwm value not on its pin");
   a_pwm_fault_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
      (pwm_alt_sel[1] && pwm_fault_mask[1] && fault_any) |=> !port_a_pin_out[1])
      else $error("fault did not gate pwm");
   a_pwm_fault_in_0_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      !flt0_alt_sel |=> !pwm_fault_in_0) else $error("pwm_fault_in_0 seen while not selected");
   a_timer_path: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!pwm_alt_sel[4] && tmr_alt_sel[0]) |=> port_a_pin_oe[4] == $past(timer_a_ch2_oe))
      else $error("timer ch2 enable lost");
   a_pwm_over_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
      (pwm_alt_sel[4] && !flt1_from_b4_sel) |=> !pwm_fault_in_1)
      else $error("pwm_fault_in_1 taken from a pwm pin");
   a_b4_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
      (flt1_from_b4_sel && !b4_sync) |=> pwm_fault_in_1) else $error("b4 fault lost");
   a_b4_fault_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!flt1_from_b4_sel && !flt_alt_sel[0]) |=> !pwm_fault_in_1)
      else $error("pwm_fault_in_1 seen with no source");

   // -------------------------------------------------------------------
   // Cover points
   // -------------------------------------------------------------------
   c_pwm_sel: cover property (@(posedge core_clk) disable iff (!rst_n) pwm_alt_sel[0]);
   c_bit7_drive: cover property (@(posedge core_clk) disable iff (!rst_n) port_a_bit7_io_oe);
   c_rst_release: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(chip_rst_n));
   c_pwm_fault_in_1: cover property (@(posedge core_clk) disable iff (!rst_n) pwm_fault_in_1);
   c_timer_sel: cover property (@(posedge core_clk) disable iff (!rst_n)
      tmr_alt_sel[0] && !pwm_alt_sel[4]);
endmodule : pamx_top

// ===== verif/pamx_board.sv
// Board model: reset button, pull-ups and fault sources on the pins.
// Assumes the bench drives the button and pull-down controls at the falling edge.
`timescale 1ns/100ps
module pamx_board
(
   input wire logic rst_btn,
   input wire logic [6:0] ext_low,
   input wire logic b4_low,
   input wire logic [6:0] pin_out,
   input wire logic [6:0] pin_oe,
   input wire logic a7_out,
   input wire logic a7_oe,
   output logic reset_pin_n,
   output logic [6:0] pin_in,
   output logic b4_in
);
   // ----------------------------------------
   // Pin levels
   // ----------------------------------------
   // Pins carry pull-ups, so an undriven pin reads high unless ext_low pulls it low, never the last value
   always_comb
   begin
      for (int i = 0; i < 7; i++)
      begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ~ext_low[i];
      end
   end
   // Wired-AND: the button and the open-drain driver can only pull low
   assign reset_pin_n = ~(rst_btn | (a7_oe & ~a7_out));
   assign b4_in = ~b4_low;
endmodule : pamx_board

// ===== verif/tb.sv
// Self-checking bench for the port A and reset pin multiplexer.
// Assumes the board model on the pins and a 10 MHz core clock.
`timescale 1ns/100ps
`include "pamx_cfg.svh"
module tb
   import pamx_pkg::*;
;
   typedef struct packed {logic [5:0] ps, pc; logic [1:0] ts; logic [6:0] dir, dout, ext, o, oe, din;} pamx_row_t;
   typedef struct packed {logic [1:0] fs; logic f0s, b4s; logic [6:0] ext; logic b4l; logic [2:0] f;} pamx_flt_t;
   logic core_clk, rst_n, por_rst, wdg_rst, sw_rst, gsel, a7_dout, a7_dir, f0sel, b4sel;
   logic t2o, t2e, t3o, t3e, rst_btn, b4_low;
   logic [6:0] gpio_dout, gpio_dir, ext_low;
   logic [5:0] psel, pch, pmask;
   logic [1:0] tsel, fsel;
   logic rpin, a7_out, a7_oe, a7_din, b4_in, t2i, t3i, f0, f1, f2, chip_rst_n;
   logic [6:0] pin_in, pin_out, pin_oe, gpio_din;
   int failures = 0;
   int n_compared = 0;
   int n;
   pamx_row_t rows [6] = '{
      '{6'h00, 6'h00, 2'h0, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h7f},
      '{6'h00, 6'h00, 2'h0, 7'h7f, 7'h55, 7'h00, 7'h55, 7'h7f, 7'h55},
      '{6'h00, 6'h00, 2'h0, 7'h0f, 7'h05, 7'h50, 7'h05, 7'h0f, 7'h25},
      '{6'h3f, 6'h2a, 2'h0, 7'h40, 7'h40, 7'h00, 7'h6a, 7'h7f, 7'h6a},
      '{6'h00, 6'h00, 2'h3, 7'h00, 7'h00, 7'h00, 7'h10, 7'h30, 7'h5f},
      '{6'h30, 6'h20, 2'h3, 7'h00, 7'h00, 7'h00, 7'h20, 7'h30, 7'h6f}};
   pamx_flt_t flts [6] = '{
      '{2'h0, 1'b0, 1'b0, 7'h70, 1'b1, 3'h0}, '{2'h0, 1'b1, 1'b0, 7'h40, 1'b0, 3'h1},
      '{2'h1, 1'b0, 1'b0, 7'h10, 1'b0, 3'h2}, '{2'h2, 1'b0, 1'b0, 7'h20, 1'b0, 3'h4},
      '{2'h0, 1'b0, 1'b1, 7'h00, 1'b1, 3'h2}, '{2'h3, 1'b1, 1'b0, 7'h00, 1'b0, 3'h0}};

   pamx_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .por_rst(por_rst),
      .watchdog_reset(wdg_rst), .sw_rst(sw_rst), .reset_pin_n_in(rpin),
      .port_a_bit7_io_out(a7_out), .port_a_bit7_io_oe(a7_oe), .rst_pin_gpio_sel(gsel),
      .port_a_bit7_dout(a7_dout), .port_a_bit7_dir(a7_dir), .port_a_bit7_din(a7_din),
      .port_a_pin_in(pin_in), .port_a_pin_out(pin_out), .port_a_pin_oe(pin_oe),
      .gpio_dout(gpio_dout), .gpio_dir(gpio_dir), .gpio_din(gpio_din),
      .pwm_alt_sel(psel), .pwm_out_ch(pch), .tmr_alt_sel(tsel), .flt_alt_sel(fsel),
      .flt0_alt_sel(f0sel), .timer_a_ch2_out(t2o), .timer_a_ch2_oe(t2e),
      .timer_a_ch3_out(t3o), .timer_a_ch3_oe(t3e), .timer_a_ch2_in(t2i),
      .timer_a_ch3_in(t3i), .port_b_bit4_in(b4_in), .flt1_from_b4_sel(b4sel),
      .pwm_fault_mask(pmask), .pwm_fault_in_0(f0), .pwm_fault_in_1(f1),
      .pwm_fault_in_2(f2), .chip_rst_n(chip_rst_n));
   pamx_board i_board (.rst_btn(rst_btn), .ext_low(ext_low), .b4_low(b4_low),
      .pin_out(pin_out), .pin_oe(pin_oe), .a7_out(a7_out), .a7_oe(a7_oe),
      .reset_pin_n(rpin), .pin_in(pin_in), .b4_in(b4_in));

   // ----------------------------------------
   // Clock and checking tasks
   // ----------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic chk_vec(input string nm, input logic [6:0] exp, input logic [6:0] got);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk_vec

   task automatic chk_bit(input string nm, input logic exp, input logic got);
      chk_vec(nm, {6'h00, exp}, {6'h00, got});
   endtask : chk_bit

   task automatic cyc(input int k);
      repeat (k) @(negedge core_clk);
   endtask : cyc

   // Internal reset must hold for the fixed count, then rise; bounded wait
   task automatic rel_chk(input int exp_n);
      n = 0;
      while (chip_rst_n !== 1'b1 && n < 40)
      begin
         cyc(1);
         n++;
      end
      chk_vec("release_count", 7'(exp_n), 7'(n));
   endtask : rel_chk

   task automatic final_report();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report

   initial
   begin
      repeat (3000) @(posedge core_clk);
      failures++;
      final_report();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {rst_n, por_rst, wdg_rst, sw_rst, gsel, a7_dout, a7_dir, f0sel, b4sel} = '0;
      {t2o, t2e, t3o, t3e, rst_btn, b4_low} = 6'b110100;
      {gpio_dout, gpio_dir, ext_low, psel, pch, pmask, tsel, fsel} = '0;
      cyc(2);
      chk_vec("oe_in_reset", 7'h00, pin_oe);
      chk_bit("chip_rst_in_reset", 1'b0, chip_rst_n);
      rst_n = 1'b1;
      rel_chk(`PAMX_RST_SYNC_CYC + 1);
      foreach (rows[i])
      begin
         {psel, pch, tsel, gpio_dir, gpio_dout, ext_low} = {rows[i].ps, rows[i].pc,
            rows[i].ts, rows[i].dir, rows[i].dout, rows[i].ext};
         cyc(6);
         chk_vec("pin_oe", rows[i].oe, pin_oe);
         chk_vec("pin_out", rows[i].o, pin_out & rows[i].oe);
         chk_vec("gpio_din", rows[i].din, gpio_din);
         chk_bit("tmr2_in", rows[i].din[4], t2i);
         chk_bit("tmr3_in", rows[i].din[5], t3i);
      end
      {psel, tsel, gpio_dir} = '0;
      for (int k = 0; k < 4; k++)
      begin
         {por_rst, wdg_rst, sw_rst, rst_btn} = 4'b1000 >> k;
         cyc(8);
         chk_bit("chip_rst_hold", 1'b0, chip_rst_n);
         {por_rst, wdg_rst, sw_rst, rst_btn} = '0;
         // The pin path adds four edges of synchronisation before the count starts
         rel_chk((k == 3) ? `PAMX_RST_SYNC_CYC + 5 : `PAMX_RST_SYNC_CYC + 1);
      end
      // Reset pin as open-drain port A bit 7
      {gsel, a7_dir, a7_dout} = 3'b111;
      cyc(6);
      chk_bit("a7_oe_high", 1'b0, a7_oe);
      chk_bit("a7_din_high", 1'b1, a7_din);
      a7_dout = 1'b0;
      cyc(6);
      chk_bit("a7_oe_low", 1'b1, a7_oe);
      chk_bit("a7_out_low", 1'b0, a7_out);
      chk_bit("a7_din_low", 1'b0, a7_din);
      a7_dir = 1'b0;
      rst_btn = 1'b1;
      cyc(30);
      chk_bit("pin_reset_ignored", 1'b1, chip_rst_n);
      chk_bit("a7_din_input", 1'b0, a7_din);
      // Pin must be high again before the reset role returns, or it resets the chip
      rst_btn = 1'b0;
      cyc(6);
      chk_bit("chip_rst_kept", 1'b1, chip_rst_n);
      gsel = 1'b0;
      // Fault routing; pins 0..3 carry PWM, channels 0 and 1 are masked
      {psel, pch, pmask} = {6'h0f, 6'h0f, 6'h03};
      foreach (flts[i])
      begin
         {fsel, f0sel, b4sel, ext_low, b4_low} = flts[i][14:3];
         cyc(8);
         chk_vec("faults", {4'h0, flts[i].f}, {4'h0, f2, f1, f0});
         chk_vec("pwm_gated", (flts[i].f != 3'h0) ? 7'h0c : 7'h0f, pin_out & 7'h0f);
      end
      final_report();
   end
endmodule : tb
